// File: shared/ebtm_pkg.sv
/*
 * constants, register map and field layout of the eight-bit interval/pwm timer.
 * assumes a 32-bit apb slave with byte offsets as printed.
 */
package ebtm_pkg;
    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [15:0] ebtm_port_direction_ctl_addr = 16'hFF22;
    localparam logic [15:0] ebtm_timer_mode_ctl_addr = 16'hFF70;
    localparam logic [15:0] ebtm_port_function_ctl_addr = 16'hFF84;
    localparam logic [15:0] ebtm_period_compare_addr = 16'hFF74;
    localparam logic [15:0] ebtm_duty_compare_addr = 16'hFF78;
    localparam logic [15:0] ebtm_port_latch_addr = 16'hFF02;
    localparam logic [15:0] ebtm_status_addr = 16'hFF7C;
    // ****************************************************************
    // reset values and fixed bits
    // ****************************************************************
    localparam logic [7:0] ebtm_mode_reset = 8'h00;
    localparam logic [7:0] ebtm_cmp_reset = 8'h00;
    localparam logic [7:0] ebtm_dir_reset = 8'hFF;
    localparam logic [7:0] ebtm_func_reset = 8'h00;
    localparam logic [7:0] ebtm_latch_reset = 8'h00;
    localparam logic [7:0] ebtm_dir_fixed_ones = 8'hF0;
    localparam logic [7:0] ebtm_func_keep_mask = 8'h0F;
    localparam logic [7:0] ebtm_count_zero = 8'h00;
    // ****************************************************************
    // mode register fields
    // ****************************************************************
    localparam int ebtm_run_bit = 7;
    localparam int ebtm_cks_hi = 6;
    localparam int ebtm_cks_lo = 4;
    localparam int ebtm_mode_hi = 3;
    localparam int ebtm_mode_lo = 2;
    localparam int ebtm_level_bit = 1;
    localparam int ebtm_oen_bit = 0;
    localparam logic [1:0] ebtm_mode_interval = 2'h0;
    localparam logic [1:0] ebtm_mode_pwm = 2'h2;
    // ****************************************************************
    // prescaler
    // ****************************************************************
    localparam logic [2:0] ebtm_cks_div1 = 3'h0;
    localparam logic [2:0] ebtm_cks_div4 = 3'h1;
    localparam logic [2:0] ebtm_cks_div16 = 3'h2;
    localparam logic [2:0] ebtm_cks_div64 = 3'h3;
    localparam logic [2:0] ebtm_cks_div4096 = 3'h4;
    localparam logic [2:0] ebtm_cks_slow128 = 3'h5;
    localparam int ebtm_presc_width = 12;
    localparam int ebtm_slow_width = 7;
    // ****************************************************************
    // types
    // ****************************************************************
    typedef struct packed {
        logic run;
        logic [2:0] cks;
        logic [1:0] mode;
        logic level;
        logic oen;
    } ebtm_mode_type;
    typedef enum logic [0:0] {
        ebtm_cmp_period = 1'b0,
        ebtm_cmp_duty = 1'b1
    } ebtm_sel_type;
endpackage : ebtm_pkg

// File: verilog/ebtm_prescaler.sv
/*
 * count clock enable generator for the timer.
 * assumes the slow oscillator arrives as a pclk-synchronous tick.
 */
`timescale 1ns/10ps
module ebtm_prescaler
    import ebtm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic [2:0] cks,
    input wire logic slow_tick,
    output logic count_en
);
    logic [ebtm_presc_width-1:0] div_q;
    logic [ebtm_slow_width-1:0] slow_q;
    wire logic [ebtm_presc_width-1:0] div_ones = '1;
    wire logic [ebtm_slow_width-1:0] slow_ones = '1;
    wire logic slow_wrap = slow_tick && (slow_q == slow_ones);
    // ****************************************************************
    // free dividers, cleared while stopped
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_q <= '0;
            slow_q <= '0;
        end
        else if (!run)
        begin
            div_q <= '0;
            slow_q <= '0;
        end
        else
        begin
            div_q <= div_q + 1'b1;
            if (slow_tick)
                slow_q <= slow_q + 1'b1;
        end
    end
    // selected enable; pulses on divider wrap
    always_comb
    begin
        case (cks)
            ebtm_cks_div1: count_en = run;
            ebtm_cks_div4: count_en = run && (div_q[1:0] == div_ones[1:0]);
            ebtm_cks_div16: count_en = run && (div_q[3:0] == div_ones[3:0]);
            ebtm_cks_div64: count_en = run && (div_q[5:0] == div_ones[5:0]);
            ebtm_cks_div4096: count_en = run && (div_q == div_ones);
            ebtm_cks_slow128: count_en = run && slow_wrap;
            default: count_en = 1'b0;
        endcase
    end
endmodule : ebtm_prescaler

// File: verilog/ebtm_timer.sv
/*
 * eight-bit interval/square-wave/pwm timer with apb registers and port controls.
 * assumes pclk-synchronous inputs and a slow oscillator tick input.
 */
`timescale 1ns/10ps
module ebtm_timer
    import ebtm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic low_speed_osc_clock,
    output logic timer_out_pin,
    output logic match_irq,
    output logic [3:0] port2_oe,
    output logic [3:0] port2_out,
    output logic [3:0] port2_analog
);
    // ****************************************************************
    // register state
    // ****************************************************************
    ebtm_mode_type mode_q;
    logic [7:0] period_q;
    logic [7:0] duty_q;
    logic [7:0] duty_pend_q;
    logic pend_q;
    logic [7:0] dir_q;
    logic [7:0] func_q;
    logic [7:0] latch_q;
    logic [7:0] count_q;
    ebtm_sel_type sel_q;
    logic tout_q;
    logic irq_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic count_en;
    // ****************************************************************
    // apb decode
    // ****************************************************************
    wire logic acc = psel && penable;
    wire logic wr = acc && pwrite && pstrb[0];
    wire logic hit_mode = (paddr == ebtm_timer_mode_ctl_addr);
    wire logic hit_per = (paddr == ebtm_period_compare_addr);
    wire logic hit_duty = (paddr == ebtm_duty_compare_addr);
    wire logic hit_dir = (paddr == ebtm_port_direction_ctl_addr);
    wire logic hit_func = (paddr == ebtm_port_function_ctl_addr);
    wire logic hit_lat = (paddr == ebtm_port_latch_addr);
    wire logic hit_stat = (paddr == ebtm_status_addr);
    wire logic hit_any = hit_mode | hit_per | hit_duty | hit_dir | hit_func | hit_lat | hit_stat;
    wire logic [7:0] wbyte = pwdata[7:0];
    wire logic [7:0] mode_bits = mode_q;
    wire logic pwm = (mode_q.mode == ebtm_mode_pwm);
    wire logic interval = (mode_q.mode == ebtm_mode_interval);
    wire logic duty_wr = wr && hit_duty;
    // read mux; status shows the counter only
    wire logic [7:0] rbyte =
        hit_mode ? mode_bits :
        hit_per ? period_q :
        hit_duty ? (pend_q ? duty_pend_q : duty_q) :
        hit_dir ? dir_q :
        hit_func ? func_q :
        hit_lat ? latch_q :
        hit_stat ? count_q : ebtm_count_zero;
    // ****************************************************************
    // count clock
    // ****************************************************************
    ebtm_prescaler u_presc (
        .pclk(pclk),
        .presetn(presetn),
        .run(mode_q.run),
        .cks(mode_q.cks),
        .slow_tick(low_speed_osc_clock),
        .count_en(count_en)
    );
    // ****************************************************************
    // compare logic
    // ****************************************************************
    wire logic [7:0] cmp_val = (pwm && sel_q == ebtm_cmp_duty) ? duty_q : period_q;
    wire logic match = count_en && (count_q == cmp_val);
    wire logic per_match = match && (sel_q == ebtm_cmp_period);
    wire logic duty_match = match && pwm && (sel_q == ebtm_cmp_duty);
    wire logic active_lvl = ~mode_q.level;
    // ****************************************************************
    // apb response, zero wait
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q <= '0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            prdata_q <= {24'h000000, rbyte};
            pslverr_q <= psel && !penable && !hit_any;
        end
    end
    assign prdata = prdata_q;
    assign pslverr = pslverr_q;
    assign pready = 1'b1;
    // ****************************************************************
    // control registers
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_q <= ebtm_mode_reset;
            period_q <= ebtm_cmp_reset;
            dir_q <= ebtm_dir_reset;
            func_q <= ebtm_func_reset;
            latch_q <= ebtm_latch_reset;
        end
        else
        begin
            if (wr && hit_mode)
                mode_q <= wbyte;
            if (wr && hit_per)
                period_q <= wbyte;
            if (wr && hit_dir)
                dir_q <= wbyte | ebtm_dir_fixed_ones;
            if (wr && hit_func)
                func_q <= wbyte & ebtm_func_keep_mask;
            if (wr && hit_lat)
                latch_q <= wbyte;
        end
    end
    // ****************************************************************
    // duty buffer: pending value loads on old-value match
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            duty_q <= ebtm_cmp_reset;
            duty_pend_q <= ebtm_cmp_reset;
            pend_q <= 1'b0;
        end
        else if (duty_wr)
        begin
            duty_pend_q <= wbyte;
            pend_q <= 1'b1;
            if (!mode_q.run)
                duty_q <= wbyte;
        end
        else if (!mode_q.run)
            pend_q <= 1'b0;
        else if (pend_q && duty_match)
        begin
            duty_q <= duty_pend_q;
            pend_q <= 1'b0;
        end
    end
    // ****************************************************************
    // counter, pointer, output, interrupt
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count_q <= ebtm_count_zero;
            sel_q <= ebtm_cmp_period;
            tout_q <= 1'b0;
            irq_q <= 1'b0;
        end
        else if (!mode_q.run)
        begin
            count_q <= ebtm_count_zero;
            sel_q <= ebtm_cmp_period;
            tout_q <= mode_q.level;
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= per_match;
            if (per_match)
            begin
                count_q <= ebtm_count_zero;
                if (interval)
                    tout_q <= ~tout_q;
                else
                begin
                    tout_q <= active_lvl;
                    sel_q <= ebtm_cmp_duty;
                end
            end
            else if (count_en)
            begin
                count_q <= count_q + 1'b1;
                if (duty_match)
                begin
                    tout_q <= mode_q.level;
                    sel_q <= ebtm_cmp_period;
                end
            end
        end
    end
    // ****************************************************************
    // pin outputs
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            timer_out_pin <= 1'b0;
            match_irq <= 1'b0;
            port2_oe <= 4'h0;
            port2_out <= 4'h0;
            port2_analog <= 4'h0;
        end
        else
        begin
            timer_out_pin <= mode_q.oen ? tout_q : mode_q.level;
            match_irq <= irq_q;
            port2_oe <= ~dir_q[3:0];
            port2_out <= {latch_q[3:1], latch_q[0] | (mode_q.oen & tout_q)};
            port2_analog <= func_q[3:0];
        end
    end
endmodule : ebtm_timer

// File: test/ebtm_timer_props.sv
/*
 * concurrent checks on the timer's apb, port and output pins.
 * assumes zero-wait apb and byte registers in prdata[7:0].
 */
`timescale 1ns/10ps
module ebtm_timer_props
    import ebtm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic timer_out_pin,
    input wire logic match_irq,
    input wire logic [3:0] port2_oe,
    input wire logic [3:0] port2_analog
);
    // ****************************************************************
    // shadow of what software wrote
    // ****************************************************************
    logic wr_en;
    logic rd_en;
    logic [7:0] mode_q;
    logic [7:0] period_q;
    logic [7:0] dir_q;
    logic [7:0] func_q;
    // completed write and read accesses
    assign wr_en = psel && penable && pready && pwrite && pstrb[0];
    assign rd_en = psel && penable && !pwrite;
    // mirror registers updated at the write edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_q <= ebtm_mode_reset;
            period_q <= ebtm_cmp_reset;
            dir_q <= ebtm_dir_reset;
            func_q <= ebtm_func_reset;
        end
        else if (wr_en)
        begin
            if (paddr == ebtm_timer_mode_ctl_addr) mode_q <= pwdata[7:0];
            if (paddr == ebtm_period_compare_addr) period_q <= pwdata[7:0];
            if (paddr == ebtm_port_direction_ctl_addr) dir_q <= pwdata[7:0] | 8'hF0;
            if (paddr == ebtm_port_function_ctl_addr) func_q <= pwdata[7:0] & 8'h0F;
        end
    end
    // ****************************************************************
    // properties
    // ****************************************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    mode_readback_a: assert property (rd_en && paddr == ebtm_timer_mode_ctl_addr
        |-> prdata == {24'h0, mode_q}) else $error("mode register read back wrong");
    period_readback_a: assert property (rd_en && paddr == ebtm_period_compare_addr
        |-> prdata == {24'h0, period_q}) else $error("period register read back wrong");
    dir_top_ones_a: assert property (rd_en && paddr == ebtm_port_direction_ctl_addr
        |-> prdata[7:4] == 4'hF) else $error("direction upper bits not one");
    func_top_zero_a: assert property (rd_en && paddr == ebtm_port_function_ctl_addr
        |-> prdata[7:4] == 4'h0) else $error("function upper bits not zero");
    oe_follows_dir_a: assert property ($stable(dir_q) [*2]
        |-> port2_oe == ~dir_q[3:0]) else $error("pin drive differs from direction");
    analog_follows_a: assert property ($stable(func_q) [*2]
        |-> port2_analog == func_q[3:0]) else $error("analog select differs");
    stop_quiet_a: assert property ((!mode_q[7]) [*3]
        |-> !match_irq) else $error("match pulse while stopped");
    idle_level_a: assert property (((!mode_q[7] || !mode_q[0]) && $stable(mode_q)) [*3]
        |-> timer_out_pin == mode_q[1]) else $error("output not at idle level");
endmodule : ebtm_timer_props
bind ebtm_timer ebtm_timer_props i_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .timer_out_pin(timer_out_pin), .match_irq(match_irq),
    .port2_oe(port2_oe), .port2_analog(port2_analog));

// File: test/ebtm_timer_test.sv
/*
 * self-checking bench for the timer: registers, interval, pwm.
 * assumes the checker is bound to the timer by its own file.
 */
`timescale 1ns/10ps
module ebtm_timer_test
    import ebtm_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic low_speed_osc_clock = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic timer_out_pin;
    logic match_irq;
    logic [3:0] port2_oe;
    logic [3:0] port2_out;
    logic [3:0] port2_analog;
    logic [7:0] rdata;
    logic rerr;
    int failures = 0;
    int check_count = 0;
    int cyc = 0;
    int divs[6] = '{1, 4, 16, 64, 4096, 256};
    ebtm_timer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .low_speed_osc_clock(low_speed_osc_clock),
        .timer_out_pin(timer_out_pin), .match_irq(match_irq), .port2_oe(port2_oe),
        .port2_out(port2_out), .port2_analog(port2_analog));
    // clock, slow tick every other cycle, hang limit
    always #10 pclk = ~pclk;
    always @(posedge pclk)
    begin
        low_speed_osc_clock <= ~low_speed_osc_clock;
        cyc <= cyc + 1;
        if (cyc == 80000)
        begin
            $display("[ERR] %0t cycle limit reached", $time);
            failures++;
            finish_test;
        end
    end
    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task finish_test;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : finish_test
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task apb(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdata = prdata[7:0];
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task rd_chk(input logic [15:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk(rdata, e);
    endtask : rd_chk
    task wait_irq;
        do @(negedge pclk); while (match_irq !== 1'b1);
    endtask : wait_irq
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task reg_check;
        rd_chk(ebtm_port_direction_ctl_addr, 8'hFF);
        rd_chk(ebtm_port_function_ctl_addr, 8'h00);
        rd_chk(ebtm_timer_mode_ctl_addr, 8'h00);
        rd_chk(ebtm_period_compare_addr, 8'h00);
        rd_chk(ebtm_duty_compare_addr, 8'h00);
        apb(1'b1, ebtm_port_direction_ctl_addr, 8'h00);
        apb(1'b1, ebtm_port_function_ctl_addr, 8'hFF);
        rd_chk(ebtm_port_direction_ctl_addr, 8'hF0);
        rd_chk(ebtm_port_function_ctl_addr, 8'h0F);
        @(negedge pclk);
        chk(port2_oe, 4'hF);
        chk(port2_analog, 4'hF);
        apb(1'b1, ebtm_timer_mode_ctl_addr, 8'h76);
        rd_chk(ebtm_timer_mode_ctl_addr, 8'h76);
        apb(1'b1, ebtm_period_compare_addr, 8'hA5);
        rd_chk(ebtm_period_compare_addr, 8'hA5);
        apb(1'b1, ebtm_port_function_ctl_addr, 8'h00);
        rd_chk(16'hFF40, 8'h00);
        chk(rerr, 1'b1);
    endtask : reg_check
    task interval_run(input logic [2:0] cks, input int div);
        int t;
        logic o1;
        apb(1'b1, ebtm_timer_mode_ctl_addr, 8'h00);
        apb(1'b1, ebtm_period_compare_addr, 8'h04);
        apb(1'b1, ebtm_timer_mode_ctl_addr, {1'b1, cks, 4'h1});
        wait_irq;
        t = cyc;
        repeat (2) @(negedge pclk);
        o1 = timer_out_pin;
        wait_irq;
        chk(cyc - t, 5 * div);
        repeat (2) @(negedge pclk);
        chk(timer_out_pin, !o1);
    endtask : interval_run
    task stop_check;
        apb(1'b1, ebtm_timer_mode_ctl_addr, 8'h00);
        apb(1'b1, ebtm_timer_mode_ctl_addr, 8'h03);
        repeat (4) @(negedge pclk);
        chk(timer_out_pin, 1'b1);
        chk(port2_out, 4'h1);
        rd_chk(ebtm_status_addr, 8'h00);
    endtask : stop_check
    task act_count(input logic lvl, input logic [7:0] m);
        int n;
        n = 0;
        repeat (10)
        begin
            @(negedge pclk);
            if (timer_out_pin === !lvl) n++;
        end
        chk(n, m + 1);
    endtask : act_count
    task pwm_run(input logic [7:0] mode, input logic [7:0] duty, input logic [7:0] dnew);
        apb(1'b1, ebtm_timer_mode_ctl_addr, 8'h00);
        apb(1'b1, ebtm_period_compare_addr, 8'h09);
        apb(1'b1, ebtm_duty_compare_addr, duty);
        apb(1'b1, ebtm_timer_mode_ctl_addr, mode);
        repeat (2) wait_irq;
        act_count(mode[1], duty);
        apb(1'b1, ebtm_duty_compare_addr, dnew);
        wait_irq;
        act_count(mode[1], duty);
        repeat (2) wait_irq;
        act_count(mode[1], dnew);
    endtask : pwm_run
    // main sequence
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        reg_check;
        for (int i = 0; i < 6; i++) interval_run(3'(i), divs[i]);
        stop_check;
        pwm_run(8'h89, 8'h03, 8'h08);
        pwm_run(8'h8B, 8'h00, 8'h06);
        finish_test;
    end
endmodule : ebtm_timer_test
